// *** giem_irq_enable_mask.sv ***
// interrupt enable mask with event flags and an axi4-lite register slave
`include "giem_regs.svh"

module giem_irq_enable_mask #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire giem_pkg::giem_flags_t event_set,
  output giem_pkg::giem_flags_t     event_flags,
  output logic                      host_irq_request_n,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------

  // word index of a byte address
  function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[`GIEM_IDX_MSB:`GIEM_IDX_LSB];
  endfunction

  // address lies in the block's window and names a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    logic       in_win;
    idx    = word_idx(a);
    in_win = (a >> (`GIEM_IDX_MSB + 1)) == '0;
    return in_win && (idx == `GIEM_IDX_FLAGS || idx == `GIEM_IDX_CLEAR ||
                      idx == `GIEM_IDX_ENABLE || idx == `GIEM_IDX_PENDING);
  endfunction

  // bit mask of the two low byte lanes
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------

  logic                  aw_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic                  w_held;
  giem_pkg::giem_wbeat_t w_beat;
  logic                  bvalid;
  logic [1:0]            bresp;
  giem_pkg::giem_answer_t rd_ans;
  logic                  rvalid;
  giem_pkg::giem_flags_t enable;
  giem_pkg::giem_flags_t flags;

  //----------------------------------------------------------------------------
  // write channel decode
  //----------------------------------------------------------------------------

  logic                  aw_take;
  logic                  w_take;
  logic                  do_write;
  logic [5:0]            wr_idx;
  logic                  wr_mapped;
  logic [15:0]           wr_lanes;
  logic [15:0]           wr_bits;
  logic                  wr_enable;
  logic                  wr_clear;
  logic                  wr_flags;
  logic [15:0]           clear_bits;
  giem_pkg::giem_flags_t next_enable;
  logic [1:0]            next_bresp;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;

  // both halves of the write are in and the last answer is gone
  assign do_write  = aw_held && w_held && !bvalid;
  assign wr_idx    = word_idx(aw_addr);
  assign wr_mapped = is_mapped(aw_addr);
  assign wr_lanes  = lane_mask(w_beat.strb);
  assign wr_bits   = w_beat.data[15:0] & wr_lanes;

  assign wr_enable = do_write && wr_mapped && wr_idx == `GIEM_IDX_ENABLE;
  assign wr_clear  = do_write && wr_mapped && wr_idx == `GIEM_IDX_CLEAR;
  assign wr_flags  = do_write && wr_mapped && wr_idx == `GIEM_IDX_FLAGS;

  // ones written to the clear register, or back to the flags, drop flags
  assign clear_bits = (wr_clear || wr_flags) ? wr_bits & `GIEM_VALID_MASK
                                             : `GIEM_ZERO16;

  // byte lanes merge; reserved positions never store
  assign next_enable = wr_enable
    ? giem_pkg::giem_flags_t'(((enable & ~wr_lanes) | wr_bits) & `GIEM_VALID_MASK)
    : enable;

  assign next_bresp = wr_mapped ? `GIEM_RESP_OKAY : `GIEM_RESP_SLVERR;

  //----------------------------------------------------------------------------
  // write channel registers
  //----------------------------------------------------------------------------

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_beat <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_beat <= '{data: s_axi_wdata, strb: s_axi_wstrb};
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `GIEM_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (s_axi_bready) begin
      bvalid <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;

  //----------------------------------------------------------------------------
  // enable mask register
  //----------------------------------------------------------------------------

  // all sources disabled until software enables them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= giem_pkg::giem_flags_t'(`GIEM_ENABLE_RST);
    end else begin
      enable <= next_enable;
    end
  end

  //----------------------------------------------------------------------------
  // event flags
  //----------------------------------------------------------------------------

  logic [15:0] flag_bits;

  giem_flag_bank #(
    .W     (16),
    .VALID (`GIEM_VALID_MASK),
    .RST   (`GIEM_FLAGS_RST)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (event_set),
    .clr     (clear_bits),
    .flags   (flag_bits)
  );

  assign flags       = giem_pkg::giem_flags_t'(flag_bits);
  assign event_flags = flags;

  //----------------------------------------------------------------------------
  // request gating
  //----------------------------------------------------------------------------

  giem_pkg::giem_flags_t src_req;
  logic                  any_req;

  assign src_req.tv_sync_fault       = flags.tv_sync_fault & enable.tv_sync_fault;
  assign src_req.frame               = flags.frame & enable.frame;
  assign src_req.dma                 = flags.dma & enable.dma;
  assign src_req.command_fault       = flags.command_fault & enable.command_fault;
  assign src_req.vertical_blank      = flags.vertical_blank & enable.vertical_blank;
  assign src_req.command_halt        = flags.command_halt & enable.command_halt;
  assign src_req.command_pause       = flags.command_pause & enable.command_pause;
  assign src_req.rsvd_hi             = 1'b0;
  assign src_req.drawing_pause_point = flags.drawing_pause_point
                                     & enable.drawing_pause_point;
  assign src_req.rsvd_lo             = 7'h00;

  // one line for all sources, straight from the two registers
  assign any_req            = |src_req;
  assign host_irq_request_n = !any_req;

  //----------------------------------------------------------------------------
  // read channel
  //----------------------------------------------------------------------------

  logic                   ar_take;
  logic [5:0]             rd_idx;
  logic                   rd_mapped;
  logic [15:0]            rd_word;
  giem_pkg::giem_answer_t next_rd_ans;

  assign s_axi_arready = !rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = word_idx(s_axi_araddr);
  assign rd_mapped     = is_mapped(s_axi_araddr);

  // clear register always reads zero; reserved bits are never stored
  assign rd_word =
    !rd_mapped                    ? `GIEM_ZERO16 :
    rd_idx == `GIEM_IDX_FLAGS     ? flags :
    rd_idx == `GIEM_IDX_ENABLE    ? enable :
    rd_idx == `GIEM_IDX_PENDING   ? src_req :
                                    `GIEM_ZERO16;

  assign next_rd_ans.data = {`GIEM_ZERO16, rd_word};
  assign next_rd_ans.resp = rd_mapped ? `GIEM_RESP_OKAY : `GIEM_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rd_ans <= '{data: `GIEM_ZERO32, resp: `GIEM_RESP_OKAY};
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rd_ans <= next_rd_ans;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rd_ans.data;
  assign s_axi_rresp  = rd_ans.resp;

endmodule

// *** giem_regs.svh ***
// register map, field masks and reset values of the graphics irq enable mask
//------------------------------------------------------------------------------
// Operation
// - enable bit 15 gates tv sync fault
// - enable bit 14 gates frame flag
// - enable bit 13 gates dma flag
// - enable bit 12 gates command fault flag
// - enable bit 11 gates vertical blank flag
// - enable bit 10 gates command halt flag
// - enable bit 9 gates command pause flag
// - enable bit 7 gates drawing pause point
// - any enabled set flag raises one request
// - request line is active low
// - writing one to clear register clears flag
//------------------------------------------------------------------------------
`ifndef GIEM_REGS_SVH
`define GIEM_REGS_SVH

// word indices; byte address is four times the index
`define GIEM_IDX_FLAGS   6'h03
`define GIEM_IDX_CLEAR   6'h04
`define GIEM_IDX_ENABLE  6'h06
`define GIEM_IDX_PENDING 6'h07

// implemented bit positions: 15 to 9 and 7
`define GIEM_VALID_MASK  16'hFE80
`define GIEM_ENABLE_RST  16'h0000
`define GIEM_FLAGS_RST   16'h0000
`define GIEM_ZERO16      16'h0000
`define GIEM_ZERO32      32'h0000_0000

// word index field of a byte address
`define GIEM_IDX_MSB     7
`define GIEM_IDX_LSB     2

`define GIEM_RESP_OKAY   2'h0
`define GIEM_RESP_SLVERR 2'h2

`endif

// *** giem_pkg.sv ***
// shared types of the graphics irq enable mask
package giem_pkg;

  // one bit per event source, same layout in flags, enables and pending
  typedef struct packed {
    logic       tv_sync_fault;
    logic       frame;
    logic       dma;
    logic       command_fault;
    logic       vertical_blank;
    logic       command_halt;
    logic       command_pause;
    logic       rsvd_hi;
    logic       drawing_pause_point;
    logic [6:0] rsvd_lo;
  } giem_flags_t;

  // write data beat held until the address arrives
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } giem_wbeat_t;

  // read answer: data and response
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } giem_answer_t;

endpackage

// *** giem_flag_bank.sv ***
// sticky event flag bank with set-over-clear priority
module giem_flag_bank #(
  parameter int           W     = 16,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] RST   = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  logic [W-1:0] next_flags;

  // an event in the same cycle as its clear is kept
  assign next_flags = ((flags & ~clr) | set) & VALID;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= RST;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// *** giem_chk.sv ***
// port assertions of the graphics irq enable mask
`include "giem_regs.svh"
module giem_chk (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire giem_pkg::giem_flags_t event_set,
  input wire giem_pkg::giem_flags_t event_flags,
  input wire logic                  host_irq_request_n,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready
);
  wire logic [15:0] st = event_set;
  wire logic [15:0] fl = event_flags;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_needs_flag: assert property (!host_irq_request_n |-> (fl & `GIEM_VALID_MASK) != 16'h0000)
    else $error("request low with no flag set");
  a_reset_quiet: assert property ($rose(aresetn) |->
    host_irq_request_n && !s_axi_bvalid && !s_axi_rvalid && fl == 16'h0000)
    else $error("not idle after reset");
  a_flag_sticky: assert property ((st & `GIEM_VALID_MASK) != 16'h0000 |=>
    (fl & $past(st) & `GIEM_VALID_MASK) == ($past(st) & `GIEM_VALID_MASK))
    else $error("set pulse did not set its flag");
  a_rsvd_zero: assert property ((fl & ~`GIEM_VALID_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_ack: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind giem_irq_enable_mask giem_chk u_chk (.aclk, .aresetn, .event_set, .event_flags, .host_irq_request_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// *** giem_host_model.sv ***
// host side model that counts interrupt requests
module giem_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic host_irq_request_n,
  output int        irq_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic low;
  // one request is taken per low phase of the line
  always @(posedge aclk) begin
    low <= aresetn && !host_irq_request_n;
    if (!aresetn)
      irq_count <= 0;
    else if (!host_irq_request_n && !low)
      irq_count <= irq_count + 1;
  end
endmodule

// *** tb_graphics_irq_enable_mask.sv ***
// self-checking bench of the irq enable mask
`include "giem_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_graphics_irq_enable_mask;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_FLG = {`GIEM_IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_CLR = {`GIEM_IDX_CLEAR, 2'b00};
  localparam logic [7:0] A_EN  = {`GIEM_IDX_ENABLE, 2'b00};
  localparam logic [7:0] A_PND = {`GIEM_IDX_PENDING, 2'b00};
  logic                  aclk = 1'b0, aresetn = 1'b0, host_irq_request_n;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]            s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]            s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic [31:0]           s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
  giem_pkg::giem_flags_t event_set = '0, event_flags;
  int                    err_count = 0, check_count = 0, cyc = 0, irq_count, m_fl = 0, m_en = 0, v;
  int                    bits[8] = '{15, 14, 13, 12, 11, 10, 9, 7};

  giem_irq_enable_mask uut (.aclk, .aresetn, .event_set, .event_flags, .host_irq_request_n,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  giem_host_model u_host (.aclk, .aresetn, .host_irq_request_n, .irq_count);

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  //--------------------------------------------------
  // bus tasks and model comparison
  //--------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ha, hw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (!s_axi_awvalid && !s_axi_wvalid) break;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(negedge aclk);
    rs = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] p);
    @(posedge aclk);
    event_set <= p;
    @(posedge aclk);
    event_set <= '0;
    m_fl |= p & `GIEM_VALID_MASK;
  endtask
  task automatic chk_all();
    #1;
    `CHK("irq_n", ((m_fl & m_en) != 0) ? 1'b0 : 1'b1, host_irq_request_n)
    `CHK("flags", 16'(m_fl), 16'(event_flags))
  endtask
  task automatic w_en(input int e);
    wr(A_EN, e);
    m_en = e & `GIEM_VALID_MASK;
    `CHK("bresp", `GIEM_RESP_OKAY, rs)
    chk_all();
  endtask
  task automatic w_clr(input int c);
    wr(A_CLR, c);
    m_fl &= ~c;
    chk_all();
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(77907));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(A_EN);
    `CHK("en_reset", 32'h0000_0000, rd)
    chk_all();
    foreach (bits[i]) begin
      pulse(16'h0001 << bits[i]);
      chk_all();
      w_en(32'h0000_0001 << bits[i]);
      w_clr(32'h0000_0001 << bits[i]);
    end
    `CHK("irq_count", 8, irq_count)
    w_en(`GIEM_VALID_MASK);
    rdw(A_EN);
    `CHK("en_rsvd", 32'(m_en), rd)
    pulse(16'hFFFF);
    rdw(A_PND);
    `CHK("pending", 32'(m_fl & m_en), rd)
    wr(A_FLG, 32'h0000_8000);
    m_fl &= ~32'h0000_8000;
    chk_all();
    // an event landing with its own clear keeps the flag
    fork
      wr(A_CLR, 32'h0000_4000);
      begin
        repeat (2) @(posedge aclk);
        event_set <= 16'h4000;
        @(posedge aclk);
        event_set <= '0;
      end
    join
    chk_all();
    wr(8'h20, 32'h0000_FFFF);
    `CHK("bad_wr", `GIEM_RESP_SLVERR, rs)
    rdw(8'h20);
    `CHK("bad_rd", `GIEM_RESP_SLVERR, rs)
    `CHK("bad_data", 32'h0000_0000, rd)
    chk_all();
    repeat (40) begin
      pulse(16'($urandom));
      w_en($urandom & `GIEM_VALID_MASK);
      v = $urandom & `GIEM_VALID_MASK;
      w_clr(v);
    end
    stop_test();
  end
endmodule
